// ==== hdl/tcw_cmp_out.sv ====
`timescale 1ns/100ps
`default_nettype none

module tcw_cmp_out
	import tcw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Mode
	input wire logic [1:0] comMode,
	input wire logic pwmMode,
	// Events
	input wire logic matchEvt,
	input wire logic bottomEvt,
	input wire logic forceEvt,
	// Port bits
	input wire logic portBit,
	input wire logic dirBit,
	// Results
	output logic ocState,
	output logic pinOut,
	output logic pinOe
);

	logic ocState_ff;
	logic nxt_ocState;
	logic pinOut_ff;
	logic pinOe_ff;

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_ocState = ocState_ff;
		if (pwmMode)
		begin
			// Bottom beats match so a compare at max stays constant
			if (bottomEvt && comMode == COM_CLEAR)
				nxt_ocState = 1'b1; // [RQ18] [RQ20]
			else if (bottomEvt && comMode == COM_SET)
				nxt_ocState = 1'b0; // [RQ18] [RQ20]
			else if (matchEvt && comMode == COM_CLEAR)
				nxt_ocState = 1'b0; // [RQ18]
			else if (matchEvt && comMode == COM_SET)
				nxt_ocState = 1'b1; // [RQ18]
			else if (matchEvt && comMode == COM_TOGGLE)
				nxt_ocState = ~ocState_ff;
		end
		else if (matchEvt || forceEvt) // [RQ6] [RQ24]
		begin
			unique case (comMode)
				COM_OFF: nxt_ocState = ocState_ff; // [RQ5]
				COM_TOGGLE: nxt_ocState = ~ocState_ff; // [RQ14] [RQ25]
				COM_CLEAR: nxt_ocState = 1'b0; // [RQ25]
				COM_SET: nxt_ocState = 1'b1; // [RQ25]
			endcase
		end
	end

	// Internal state survives mode changes and pin disable
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ocState_ff <= 1'b0;
		else
			ocState_ff <= nxt_ocState; // [RQ4]
	end

	// Override independent of waveform mode; direction left to software
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinOut_ff <= 1'b0;
			pinOe_ff <= 1'b0;
		end
		else
		begin
			pinOut_ff <= (comMode != COM_OFF) ? nxt_ocState : portBit; // [RQ1] [RQ3]
			pinOe_ff <= dirBit; // [RQ1] [RQ2]
		end
	end

	assign ocState = ocState_ff;
	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;

endmodule

`default_nettype wire

// ==== hdl/tcw_pkg.sv ====
package tcw_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_COMPARE = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_PORT = 8'h10;

	// Control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_COM_LSB = 2;
	localparam int CTRL_RUN_BIT = 4;
	localparam int CTRL_FORCE_BIT = 5;

	// Flag field positions
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;

	// Port field positions
	localparam int PORT_DATA_BIT = 0;
	localparam int PORT_DIR_BIT = 1;
	localparam int PORT_PIN_BIT = 2;
	localparam int PORT_OCS_BIT = 3;

	// Reset values and counter limits
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// Waveform modes
	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'b00,
		WAVE_PHASE = 2'b01,
		WAVE_CLEAR = 2'b10,
		WAVE_FAST = 2'b11
	} tcw_wave_t;

	// Compare output modes
	typedef enum logic [1:0] {
		COM_OFF = 2'b00,
		COM_TOGGLE = 2'b01,
		COM_CLEAR = 2'b10,
		COM_SET = 2'b11
	} tcw_com_t;

endpackage

// ==== hdl/tcw_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

// How it works
// RQ1: Nonzero output mode routes compare state to pin; direction bit keeps control.
// RQ2: Software sets pin direction to output before expecting the waveform.
// RQ3: Pin override works identically in every waveform mode.
// RQ4: Compare state lives in its own register, settable before pin enable.
// RQ5: Output mode zero leaves compare state unchanged on a match.
// RQ6: New output mode acts at next match; force applies it at once.
// RQ7: Output mode never alters counting; waveform mode alone picks sequence.
// RQ8: Normal mode increments only, wrapping from 0xFF to 0x00.
// RQ9: Normal mode sets overflow flag in the cycle count becomes zero.
// RQ10: Counting logic only sets the overflow flag; software clears it.
// RQ11: Clear-on-match mode clears counter when it equals compare value.
// RQ12: Clear-on-match compare is unbuffered; low value means wrap first.
// RQ13: Clear-on-match raises compare flag each time count reaches top.
// RQ14: Clear-on-match toggle mode flips output on every match.
// RQ15: Clear-on-match sets overflow flag as count passes max to zero.
// RQ16: Fast PWM counts zero to max then restarts at zero.
// RQ17: Fast PWM clears counter the cycle after reaching max.
// RQ18: Fast PWM mode two non-inverted, mode three inverted.
// RQ19: Fast PWM sets overflow flag each time count reaches max.
// RQ20: Fast PWM compare zero gives spike; compare max gives constant level.
// RQ21: Compare value double buffered in PWM, direct in other modes.
// RQ22: Compare flag set cycle after match; writing one clears it.
// RQ23: Count write blocks a match in the following timer cycle.
// RQ24: Force updates output only; no flag, no counter clear.
// RQ25: Non-PWM output modes one, two, three toggle, clear, set.
module tcw_timer
	import tcw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Compare output pin
	input wire logic compareOutputIn,
	output logic compareOutputOut,
	output logic compareOutputOe
);

	////////////////////////////////////////////////////////////////////
	// Bus slave state

	logic dataPhase_ff;
	logic dataWrite_ff;
	logic [7:0] dataAddr_ff;
	logic readWait_ff;
	logic [31:0] hrdata_ff;
	logic busTake;
	logic wrEn;
	logic rdLoad;

	// Timer state
	logic [1:0] waveformMode_ff;
	logic [1:0] compareOutputMode_ff;
	logic runEn_ff;
	logic [7:0] countValue_ff;
	logic [7:0] compareBuf_ff;
	logic [7:0] compareWork_ff;
	logic overflowFlag_ff;
	logic compareFlag_ff;
	logic blockMatch_ff;
	logic portData_ff;
	logic outputPinDirectionBit_ff;
	logic pinSync1_ff;
	logic pinSync2_ff;

	// Events
	logic tick;
	logic pwmMode;
	logic match;
	logic matchEvt;
	logic atMax;
	logic forceStrobe;
	logic forceEvt_ff;
	logic ctcClear;
	logic ocState;
	logic [7:0] nxt_countValue;

	////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic isWrite(input logic [7:0] addr, input logic [7:0] ofs);
		isWrite = (addr == ofs);
	endfunction

	function automatic logic [31:0] readMux(input logic [7:0] addr);
		logic [31:0] val;
		val = 32'h0000_0000;
		unique case (addr)
			OFS_CTRL:
			begin
				val[CTRL_MODE_LSB +: 2] = waveformMode_ff;
				val[CTRL_COM_LSB +: 2] = compareOutputMode_ff;
				val[CTRL_RUN_BIT] = runEn_ff;
			end
			OFS_COUNT: val[7:0] = countValue_ff;
			OFS_COMPARE: val[7:0] = compareBuf_ff;
			OFS_FLAGS:
			begin
				val[FLAG_OVF_BIT] = overflowFlag_ff;
				val[FLAG_CMP_BIT] = compareFlag_ff;
			end
			OFS_PORT:
			begin
				val[PORT_DATA_BIT] = portData_ff;
				val[PORT_DIR_BIT] = outputPinDirectionBit_ff;
				val[PORT_PIN_BIT] = pinSync2_ff;
				val[PORT_OCS_BIT] = ocState;
			end
			default: val = 32'h0000_0000;
		endcase
		readMux = val;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bus handshake

	assign busTake = hsel && htrans[1] && hready;
	assign wrEn = dataPhase_ff && dataWrite_ff;
	// Reads wait one cycle because the read data is sampled into a register first
	assign rdLoad = dataPhase_ff && !dataWrite_ff && !readWait_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dataPhase_ff <= 1'b0;
			dataWrite_ff <= 1'b0;
			dataAddr_ff <= 8'h00;
		end
		else if (hready || readWait_ff)
		begin
			dataPhase_ff <= busTake;
			dataWrite_ff <= hwrite;
			dataAddr_ff <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			readWait_ff <= 1'b0;
		else
			readWait_ff <= rdLoad;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hrdata_ff <= 32'h0000_0000;
		else if (rdLoad)
			hrdata_ff <= readMux(dataAddr_ff);
	end

	assign hreadyout = !rdLoad;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	////////////////////////////////////////////////////////////////////
	// Control and port registers

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			waveformMode_ff <= WAVE_NORMAL;
			compareOutputMode_ff <= COM_OFF;
			runEn_ff <= 1'b0;
		end
		else if (wrEn && isWrite(dataAddr_ff, OFS_CTRL))
		begin
			waveformMode_ff <= hwdata[CTRL_MODE_LSB +: 2];
			compareOutputMode_ff <= hwdata[CTRL_COM_LSB +: 2];
			runEn_ff <= hwdata[CTRL_RUN_BIT];
		end
	end

	// Delayed one clock so the strobe acts with the output mode written alongside it
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			forceEvt_ff <= 1'b0;
		else
			forceEvt_ff <= forceStrobe; // [RQ6] [RQ24]
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			portData_ff <= 1'b0;
			outputPinDirectionBit_ff <= 1'b0;
		end
		else if (wrEn && isWrite(dataAddr_ff, OFS_PORT))
		begin
			portData_ff <= hwdata[PORT_DATA_BIT];
			outputPinDirectionBit_ff <= hwdata[PORT_DIR_BIT];
		end
	end

	// Pin level is asynchronous to clk
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinSync1_ff <= 1'b0;
			pinSync2_ff <= 1'b0;
		end
		else
		begin
			pinSync1_ff <= compareOutputIn;
			pinSync2_ff <= pinSync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Compare value buffering

	assign pwmMode = waveformMode_ff[0];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			compareBuf_ff <= RST_COMPARE;
		else if (wrEn && isWrite(dataAddr_ff, OFS_COMPARE))
			compareBuf_ff <= hwdata[7:0];
	end

	// PWM loads working copy at top, avoiding odd-length pulses
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			compareWork_ff <= RST_COMPARE;
		else if (!pwmMode && wrEn && isWrite(dataAddr_ff, OFS_COMPARE))
			compareWork_ff <= hwdata[7:0]; // [RQ21] [RQ12]
		else if (!pwmMode)
			compareWork_ff <= compareBuf_ff; // [RQ21]
		else if (atMax)
			compareWork_ff <= compareBuf_ff; // [RQ21]
	end

	////////////////////////////////////////////////////////////////////
	// Counter

	assign tick = runEn_ff;
	assign match = (countValue_ff == compareWork_ff) && !blockMatch_ff; // [RQ23]
	assign matchEvt = tick && match;
	assign atMax = tick && (countValue_ff == CNT_MAX);
	assign ctcClear = (waveformMode_ff == WAVE_CLEAR) && matchEvt; // [RQ11] [RQ12]

	// Output mode deliberately absent from the sequence
	always_comb
	begin
		nxt_countValue = countValue_ff;
		if (tick)
		begin
			unique case (waveformMode_ff)
				WAVE_CLEAR:
					nxt_countValue = ctcClear ? CNT_BOTTOM : countValue_ff + 8'h01; // [RQ11]
				WAVE_FAST:
					nxt_countValue = atMax ? CNT_BOTTOM : countValue_ff + 8'h01; // [RQ16] [RQ17]
				default:
					nxt_countValue = countValue_ff + 8'h01; // [RQ8] [RQ7]
			endcase
		end
	end

	// Software write has priority over counting
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			countValue_ff <= RST_COUNT;
		else if (wrEn && isWrite(dataAddr_ff, OFS_COUNT))
			countValue_ff <= hwdata[7:0];
		else
			countValue_ff <= nxt_countValue;
	end

	// Held until a timer cycle passes, so a stopped timer still blocks
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			blockMatch_ff <= 1'b0;
		else if (wrEn && isWrite(dataAddr_ff, OFS_COUNT))
			blockMatch_ff <= 1'b1; // [RQ23]
		else if (tick)
			blockMatch_ff <= 1'b0; // [RQ23]
	end

	////////////////////////////////////////////////////////////////////
	// Flags: a set in the clearing cycle wins

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			overflowFlag_ff <= 1'b0;
		else if (atMax)
			overflowFlag_ff <= 1'b1; // [RQ9] [RQ15] [RQ19]
		else if (wrEn && isWrite(dataAddr_ff, OFS_FLAGS) && hwdata[FLAG_OVF_BIT])
			overflowFlag_ff <= 1'b0; // [RQ10]
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			compareFlag_ff <= 1'b0;
		else if (matchEvt)
			compareFlag_ff <= 1'b1; // [RQ22] [RQ13]
		else if (wrEn && isWrite(dataAddr_ff, OFS_FLAGS) && hwdata[FLAG_CMP_BIT])
			compareFlag_ff <= 1'b0; // [RQ22]
	end

	////////////////////////////////////////////////////////////////////
	// Compare output unit

	assign forceStrobe = wrEn && isWrite(dataAddr_ff, OFS_CTRL) && hwdata[CTRL_FORCE_BIT]
		&& !hwdata[CTRL_MODE_LSB]; // [RQ6] [RQ24]

	tcw_cmp_out i_tcw_cmp_out (
		.clk(clk),
		.rst_b(rst_b),
		.comMode(compareOutputMode_ff),
		.pwmMode(pwmMode),
		.matchEvt(matchEvt),
		.bottomEvt(atMax && waveformMode_ff == WAVE_FAST),
		.forceEvt(forceEvt_ff),
		.portBit(portData_ff),
		.dirBit(outputPinDirectionBit_ff),
		.ocState(ocState),
		.pinOut(compareOutputOut),
		.pinOe(compareOutputOe)
	);

endmodule

`default_nettype wire

// ==== test/tcw_pin_load.sv ====
`timescale 1ns/100ps
`default_nettype none
module tcw_pin_load
(
	// From the block
	input wire logic drvOut,
	input wire logic drvOe,
	// Pin level
	output logic pinLvl
);
	// Load has a pull-down, so a released pin reads low
	assign pinLvl = drvOe ? drvOut : 1'h0;
endmodule
`default_nettype wire

// ==== test/tcw_timer_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module tcw_timer_properties
	import tcw_pkg::*;
(
	// Clock, reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Pin
	input wire logic compareOutputOut,
	input wire logic compareOutputOe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic wr_ff, rd_ff;
	logic [1:0] port_ff;
	logic [7:0] adr_ff, ctl_ff, cmp_ff;
	logic [8:0] quiet_ff;
	wire logic take = hsel && htrans[1] && hready;
	wire logic land = wr_ff && hready;
	wire logic comOff = ctl_ff[3:2] == 2'h0;
	wire logic sqrOn = quiet_ff > 9'h008 && ctl_ff[4:0] == 5'h16 && cmp_ff == 8'h00;
	// Settle time covers one full period
	wire logic lvlOn = quiet_ff > 9'h12C && (ctl_ff[4:0] | 5'h04) == 5'h1F && cmp_ff == 8'hFF;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			wr_ff <= 1'h0;
			rd_ff <= 1'h0;
			adr_ff <= 8'h00;
		end
		else if (hready)
		begin
			wr_ff <= take && hwrite;
			rd_ff <= take && !hwrite;
			adr_ff <= {haddr[7:2], 2'h0};
		end
	// Shadow of written settings
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			ctl_ff <= 8'h00;
			cmp_ff <= 8'h00;
			port_ff <= 2'h0;
		end
		else if (land && adr_ff == OFS_CTRL)
			ctl_ff <= hwdata[7:0];
		else if (land && adr_ff == OFS_COMPARE)
			cmp_ff <= hwdata[7:0];
		else if (land && adr_ff == OFS_PORT)
			port_ff <= hwdata[1:0];
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			quiet_ff <= 9'h000;
		else if (land)
			quiet_ff <= 9'h000;
		else if (quiet_ff != 9'h1FF)
			quiet_ff <= quiet_ff + 9'h001;
	////////////////////////////////////////////////////////////////
	okay_resp_a: assert property (!hresp) else $error("resp not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write wait");
	unmapped_zero_a: assert property (rd_ff && hreadyout && adr_ff > OFS_PORT |-> hrdata == 0)
		else $error("unmapped read");
	pin_source_a: assert property ($past(comOff) |-> compareOutputOut == $past(port_ff[0]))
		else $error("pin source");
	pin_dir_a: assert property (compareOutputOe == $past(port_ff[1]))
		else $error("pin direction");
	ctc_square_a: assert property (sqrOn |-> compareOutputOut != $past(compareOutputOut))
		else $error("no toggle");
	pwm_level_a: assert property (lvlOn |-> compareOutputOut == !ctl_ff[2])
		else $error("level wrong");
	cover property (sqrOn);
	cover property (lvlOn);
	cover property (rd_ff && hreadyout && adr_ff > OFS_PORT);
endmodule
bind tcw_timer tcw_timer_properties i_tcw_timer_properties (.clk, .rst_b, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .compareOutputOut,
	.compareOutputOe);
`default_nettype wire

// ==== test/tcw_timer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
	begin totalChecks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tcw_timer_tb
	import tcw_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic hsel = 1'h1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, r;
	logic hrdy, hresp, pin, oOut, oOe;
	int fails = 0;
	int totalChecks = 0;
	int cyc = 0;
	tcw_timer i_tcw_timer (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .compareOutputIn(pin),
		.compareOutputOut(oOut), .compareOutputOe(oOe));
	tcw_pin_load i_tcw_pin_load (.drvOut(oOut), .drvOe(oOe), .pinLvl(pin));
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			fails++;
			giveVerdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'h1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic run(input logic [31:0] c, input int n);
		wr(OFS_CTRL, c);
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic tReset();
		wr(8'h14, 32'hFFFFFFFF);
		for (int i = 0; i < 6; i++)
		begin
			rd(8'(i * 4));
			`CHK(r, 32'h0)
		end
		$display("reset done");
	endtask
	task automatic tForce();
		logic [7:0] cw [5] = '{8'h24, 8'h28, 8'h2C, 8'h24, 8'h20};
		logic [4:0] ex = 5'h05;
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_CTRL, {24'h0, cw[i]});
			rd(OFS_PORT);
			`CHK(r[PORT_OCS_BIT], ex[i])
		end
		// Checked before running, since a real match at count zero sets the flag
		rd(OFS_FLAGS);
		`CHK(r[FLAG_CMP_BIT], 1'h0)
		run(32'h2C, 4);
		rd(OFS_PORT);
		`CHK(r[PORT_PIN_BIT], 1'h0)
		wr(OFS_PORT, 32'h2);
		repeat (4) @(posedge clk);
		rd(OFS_PORT);
		`CHK(r[PORT_PIN_BIT], 1'h1)
		$display("force done");
	endtask
	task automatic tNormal();
		wr(OFS_CTRL, 32'h0);
		wr(OFS_FLAGS, 32'h3);
		wr(OFS_COUNT, 32'hF0);
		run(32'h14, 20);
		run(32'h0, 0);
		rd(OFS_COUNT);
		`CHK(r[7:0] < 8'h30, 1'h1)
		rd(OFS_FLAGS);
		`CHK(r[FLAG_OVF_BIT], 1'h1)
		wr(OFS_FLAGS, 32'h1);
		rd(OFS_FLAGS);
		`CHK(r[FLAG_OVF_BIT], 1'h0)
		$display("normal done");
	endtask
	task automatic tBlock();
		wr(OFS_COMPARE, 32'h5);
		wr(OFS_COUNT, 32'h5);
		wr(OFS_FLAGS, 32'h3);
		run(32'h10, 10);
		run(32'h0, 0);
		rd(OFS_FLAGS);
		`CHK(r[FLAG_CMP_BIT], 1'h0)
		wr(OFS_COUNT, 32'h3);
		run(32'h10, 10);
		run(32'h0, 0);
		rd(OFS_FLAGS);
		`CHK(r[FLAG_CMP_BIT], 1'h1)
		wr(OFS_FLAGS, 32'h2);
		rd(OFS_FLAGS);
		`CHK(r[FLAG_CMP_BIT], 1'h0)
		$display("block done");
	endtask
	task automatic tCtc();
		// Count write blocks the first match, so start just below the wrap
		wr(OFS_COUNT, 32'hFF);
		wr(OFS_COMPARE, 32'h0);
		run(32'h16, 20);
		rd(OFS_COUNT);
		`CHK(r, 32'h0)
		rd(OFS_FLAGS);
		`CHK(r[FLAG_CMP_BIT], 1'h1)
		run(32'h0, 0);
		wr(OFS_COUNT, 32'h20);
		wr(OFS_COMPARE, 32'h10);
		wr(OFS_FLAGS, 32'h3);
		run(32'h12, 100);
		rd(OFS_COUNT);
		`CHK(r[7:0] > 8'h80, 1'h1)
		repeat (200) @(posedge clk);
		rd(OFS_COUNT);
		`CHK(r[7:0] <= 8'h10, 1'h1)
		rd(OFS_FLAGS);
		`CHK(r[FLAG_OVF_BIT], 1'h1)
		$display("clear mode done");
	endtask
	task automatic tPwm();
		logic [7:0] cv [6] = '{8'h80, 8'h80, 8'hFF, 8'hFF, 8'h00, 8'h00};
		logic [8:0] ex [6] = '{9'h081, 9'h07F, 9'h100, 9'h000, 9'h001, 9'h0FF};
		logic [8:0] hi;
		for (int i = 0; i < 6; i++)
		begin
			run(32'h0, 0);
			wr(OFS_COMPARE, {24'h0, cv[i]});
			run({29'h0000003, i[0], 2'h3}, 300);
			hi = 9'h000;
			repeat (256)
			begin
				@(posedge clk);
				hi = hi + {8'h00, pin};
			end
			`CHK(hi, ex[i])
		end
		$display("pwm done");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		tReset();
		tForce();
		tNormal();
		tBlock();
		tCtc();
		tPwm();
		giveVerdict();
	end
endmodule
`default_nettype wire
